// ### pifb_flag_bank.sv
// Operation
// - hardware sets flags regardless of enables
// - hardware-set writable flags stick until written
// - pwm b param flag mirrors group register
// - spi b summary mirrors its flag register
// - spi b tx/rx flags ignore writes
// - register six layout, writable, reset zero
// - register seven layout and access
// - pwm c param flag mirrors group register
// - twi error flag mirrors error register
// - twi summary mirrors protocol flag register
// - twi tx/rx drop on buffer clear
// - register eight layout and access
// - one means event occurred since clear
// - uart b summary mirrors flag register
// - uart b framing mirrors error register
// - uart b tx/rx flags ignore writes
`timescale 1ns/1ps
`default_nettype none

module pifb_flag_bank
  import pifb_pkg::*;
#(
  parameter int PWM_GRP_W = 8,
  parameter int SPI_FLAG_W = 8,
  parameter int TWI_ERR_W = 8,
  parameter int TWI_PROTO_W = 8,
  parameter int UART_FLAG_W = 8,
  parameter int UART_ERR_W = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pifb_pkg::APB_AW-1:0] paddr,
  input wire logic [pifb_pkg::APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pifb_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // one-cycle event pulses from the peripherals
  input wire logic dma_b_abort_evt,
  input wire logic dma_b_overrun_evt,
  input wire logic dma_b_dest_count_evt,
  input wire logic dma_b_src_count_evt,
  input wire logic num_osc_evt,
  input wire logic wave_gen_evt,
  input wire logic ext_irq_one_evt,
  input wire logic pwm_c_period_evt,
  input wire logic logic_cell_c_evt,
  input wire logic mem_scanner_evt,
  input wire logic logic_cell_d_evt,
  input wire logic twi_a_tx_evt,
  input wire logic twi_a_rx_evt,
  input wire logic buffer_clear_bit,
  // levels owned by the peripherals
  input wire logic [PWM_GRP_W-1:0] pwm_b_group_flag_reg,
  input wire logic [PWM_GRP_W-1:0] pwm_c_group_flag_reg,
  input wire logic [SPI_FLAG_W-1:0] spi_b_flag_reg,
  input wire logic spi_b_tx_req,
  input wire logic spi_b_rx_req,
  input wire logic [TWI_ERR_W-1:0] twi_a_error_reg,
  input wire logic [TWI_PROTO_W-1:0] twi_a_protocol_flag_reg,
  input wire logic [UART_FLAG_W-1:0] uart_b_flag_reg,
  input wire logic [UART_ERR_W-1:0] uart_b_error_reg,
  input wire logic uart_b_tx_req,
  input wire logic uart_b_rx_req,
  // flag registers towards the cpu interrupt logic
  output logic [pifb_pkg::FLAG_W-1:0] periph_irq_req_five,
  output logic [pifb_pkg::FLAG_W-1:0] periph_irq_req_six,
  output logic [pifb_pkg::FLAG_W-1:0] periph_irq_req_seven,
  output logic [pifb_pkg::FLAG_W-1:0] periph_irq_req_eight,
  output logic irq
);

  import pifb_pkg::*;

  localparam int STICKY_W = 11;

  // apb decode
  logic setup_cyc;
  logic access_done;
  logic wr_done;
  logic prep_q;
  logic [APB_DW-1:0] prdata_q;
  logic [APB_DW-1:0] rd_mux;
  logic addr_hit;
  logic lane0_wr;

  assign setup_cyc = psel & ~penable;
  // one wait-free access phase after each setup that saw ce high
  assign pready = psel & penable & ce & prep_q;
  assign access_done = pready;
  assign wr_done = access_done & pwrite;
  // registers hold their byte in lane 0
  assign lane0_wr = wr_done & pstrb[0] & ~paddr[1] & ~paddr[0];

  always_comb begin
    addr_hit = 1'b1;
    unique case (paddr)
      ADDR_REQ_FIVE, ADDR_REQ_SIX, ADDR_REQ_SEVEN, ADDR_REQ_EIGHT: addr_hit = 1'b1;
      ADDR_IRQ_STATUS, ADDR_IRQ_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pslverr = access_done & ~addr_hit;

  logic wr_six;
  logic wr_seven;
  logic wr_eight;
  logic wr_status;
  logic wr_mask;

  assign wr_six = lane0_wr & (paddr == ADDR_REQ_SIX);
  assign wr_seven = lane0_wr & (paddr == ADDR_REQ_SEVEN);
  assign wr_eight = lane0_wr & (paddr == ADDR_REQ_EIGHT);
  assign wr_status = lane0_wr & (paddr == ADDR_IRQ_STATUS);
  assign wr_mask = lane0_wr & (paddr == ADDR_IRQ_MASK);

  // hardware-set writable flags
  logic [STICKY_W-1:0] sticky_set;
  logic [STICKY_W-1:0] sticky_wen;
  logic [STICKY_W-1:0] sticky_wdata;
  logic [STICKY_W-1:0] sticky_q;

  assign sticky_set = {dma_b_abort_evt, dma_b_overrun_evt, dma_b_dest_count_evt, dma_b_src_count_evt,
                       num_osc_evt, wave_gen_evt, ext_irq_one_evt, pwm_c_period_evt, logic_cell_c_evt,
                       mem_scanner_evt, logic_cell_d_evt};
  assign sticky_wen[10:4] = {7{wr_six}};
  assign sticky_wdata[10:4] = {pwdata[B6_DMA_B_ABORT], pwdata[B6_DMA_B_OVERRUN], pwdata[B6_DMA_B_DEST],
                               pwdata[B6_DMA_B_SRC], pwdata[B6_NUM_OSC], pwdata[B6_WAVE_GEN],
                               pwdata[B6_EXT_IRQ_ONE]};
  assign sticky_wen[3:2] = {2{wr_seven}};
  assign sticky_wdata[3:2] = {pwdata[B7_PWM_C_PERIOD], pwdata[B7_LOGIC_CELL_C]};
  assign sticky_wen[1:0] = {2{wr_eight}};
  assign sticky_wdata[1:0] = {pwdata[B8_MEM_SCANNER], pwdata[B8_LOGIC_CELL_D]};

  pifb_sticky_bank #(
    .W(STICKY_W)
  ) u_sticky (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .set_evt(sticky_set),
    .wr_en(sticky_wen),
    .wr_data(sticky_wdata),
    .flag_q(sticky_q)
  );

  // read-only mirrors of peripheral registers
  logic pwm_b_param_flag;
  logic pwm_c_param_flag;
  logic spi_b_summary_flag;
  logic twi_a_error_flag;
  logic twi_a_summary_flag;
  logic uart_b_summary_flag;
  logic uart_b_framing_flag;

  // clears only with whole group register
  pifb_mirror #(.W(PWM_GRP_W)) u_pwm_b (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .src(pwm_b_group_flag_reg), .flag_q(pwm_b_param_flag)
  );
  // clears only with whole group register
  pifb_mirror #(.W(PWM_GRP_W)) u_pwm_c (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .src(pwm_c_group_flag_reg), .flag_q(pwm_c_param_flag)
  );
  pifb_mirror #(.W(SPI_FLAG_W)) u_spi_b (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .src(spi_b_flag_reg), .flag_q(spi_b_summary_flag)
  );
  pifb_mirror #(.W(TWI_ERR_W)) u_twi_err (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .src(twi_a_error_reg), .flag_q(twi_a_error_flag)
  );
  pifb_mirror #(.W(TWI_PROTO_W)) u_twi_sum (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .src(twi_a_protocol_flag_reg), .flag_q(twi_a_summary_flag)
  );
  pifb_mirror #(.W(UART_FLAG_W)) u_uart_sum (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .src(uart_b_flag_reg), .flag_q(uart_b_summary_flag)
  );
  pifb_mirror #(.W(UART_ERR_W)) u_uart_err (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .src(uart_b_error_reg), .flag_q(uart_b_framing_flag)
  );

  // tx/rx request levels owned by the peripheral
  logic spi_b_tx_flag_q;
  logic spi_b_rx_flag_q;
  logic uart_b_tx_flag_q;
  logic uart_b_rx_flag_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      spi_b_tx_flag_q <= 1'b0;
      spi_b_rx_flag_q <= 1'b0;
      uart_b_tx_flag_q <= 1'b0;
      uart_b_rx_flag_q <= 1'b0;
    end else if (ce) begin
      // no write path to spi tx/rx
      spi_b_tx_flag_q <= spi_b_tx_req;
      spi_b_rx_flag_q <= spi_b_rx_req;
      // no write path to uart tx/rx
      uart_b_tx_flag_q <= uart_b_tx_req;
      uart_b_rx_flag_q <= uart_b_rx_req;
    end
  end

  // twi tx/rx: latched, dropped by the buffer clear
  logic twi_a_tx_flag_q;
  logic twi_a_rx_flag_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      twi_a_tx_flag_q <= 1'b0;
      twi_a_rx_flag_q <= 1'b0;
    end else if (ce) begin
      // buffer clear drops both, new event wins
      if (twi_a_tx_evt) begin
        twi_a_tx_flag_q <= 1'b1;
      end else if (buffer_clear_bit) begin
        twi_a_tx_flag_q <= 1'b0;
      end
      if (twi_a_rx_evt) begin
        twi_a_rx_flag_q <= 1'b1;
      end else if (buffer_clear_bit) begin
        twi_a_rx_flag_q <= 1'b0;
      end
    end
  end

  // register images; unused positions stay zero
  always_comb begin
    periph_irq_req_five = REQ_RESET;
    periph_irq_req_six = REQ_RESET;
    periph_irq_req_seven = REQ_RESET;
    periph_irq_req_eight = REQ_RESET;
    // set bit reports an uncleared event
    periph_irq_req_five[B5_PWM_B_PARAM] = pwm_b_param_flag;
    periph_irq_req_five[B5_SPI_B_SUMMARY] = spi_b_summary_flag;
    periph_irq_req_five[B5_SPI_B_TX] = spi_b_tx_flag_q;
    periph_irq_req_five[B5_SPI_B_RX] = spi_b_rx_flag_q;
    periph_irq_req_six[B6_DMA_B_ABORT] = sticky_q[10];
    periph_irq_req_six[B6_DMA_B_OVERRUN] = sticky_q[9];
    periph_irq_req_six[B6_DMA_B_DEST] = sticky_q[8];
    periph_irq_req_six[B6_DMA_B_SRC] = sticky_q[7];
    periph_irq_req_six[B6_NUM_OSC] = sticky_q[6];
    periph_irq_req_six[B6_WAVE_GEN] = sticky_q[5];
    periph_irq_req_six[B6_EXT_IRQ_ONE] = sticky_q[4];
    periph_irq_req_seven[B7_PWM_C_PARAM] = pwm_c_param_flag;
    periph_irq_req_seven[B7_PWM_C_PERIOD] = sticky_q[3];
    periph_irq_req_seven[B7_LOGIC_CELL_C] = sticky_q[2];
    periph_irq_req_seven[B7_TWI_A_ERROR] = twi_a_error_flag;
    periph_irq_req_seven[B7_TWI_A_SUMMARY] = twi_a_summary_flag;
    periph_irq_req_seven[B7_TWI_A_TX] = twi_a_tx_flag_q;
    periph_irq_req_seven[B7_TWI_A_RX] = twi_a_rx_flag_q;
    periph_irq_req_eight[B8_MEM_SCANNER] = sticky_q[1];
    periph_irq_req_eight[B8_LOGIC_CELL_D] = sticky_q[0];
    periph_irq_req_eight[B8_UART_B_SUMMARY] = uart_b_summary_flag;
    periph_irq_req_eight[B8_UART_B_FRAMING] = uart_b_framing_flag;
    periph_irq_req_eight[B8_UART_B_TX] = uart_b_tx_flag_q;
    periph_irq_req_eight[B8_UART_B_RX] = uart_b_rx_flag_q;
  end

  // interrupt status: one bit per register, set when the register goes from no flag set to any flag set
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] any_flag;
  logic [IRQ_W-1:0] any_flag_q;
  logic [IRQ_W-1:0] irq_evt;

  assign any_flag = {|periph_irq_req_eight, |periph_irq_req_seven, |periph_irq_req_six, |periph_irq_req_five};
  // a register going from idle to flagged is one event
  assign irq_evt = any_flag & ~any_flag_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      any_flag_q <= IRQ_STATUS_RESET;
    end else if (ce) begin
      any_flag_q <= any_flag;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_status_q <= IRQ_STATUS_RESET;
    end else if (ce) begin
      // set beats a simultaneous write-one-to-clear
      irq_status_q <= irq_evt | (irq_status_q & ~(wr_status ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}}));
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (ce && wr_mask) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // read data sampled at the setup edge, held through access
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      ADDR_REQ_FIVE: rd_mux[FLAG_W-1:0] = periph_irq_req_five;
      ADDR_REQ_SIX: rd_mux[FLAG_W-1:0] = periph_irq_req_six;
      ADDR_REQ_SEVEN: rd_mux[FLAG_W-1:0] = periph_irq_req_seven;
      ADDR_REQ_EIGHT: rd_mux[FLAG_W-1:0] = periph_irq_req_eight;
      ADDR_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_q;
      ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prep_q <= 1'b0;
      prdata_q <= '0;
    end else if (ce) begin
      // a setup missed while ce was low is caught in its access phase; pready would never come
      if (setup_cyc || (psel && penable && !prep_q)) begin
        prep_q <= 1'b1;
        prdata_q <= pwrite ? '0 : rd_mux;
      end else if (access_done) begin
        prep_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;

endmodule : pifb_flag_bank

`default_nettype wire

// ### pifb_flag_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none

module pifb_flag_bank_sva
  import pifb_pkg::*;
#(
  parameter int PWM_GRP_W = 8,
  parameter int SPI_FLAG_W = 8,
  parameter int TWI_ERR_W = 8,
  parameter int TWI_PROTO_W = 8,
  parameter int UART_FLAG_W = 8,
  parameter int UART_ERR_W = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pifb_pkg::APB_AW-1:0] paddr,
  input wire logic [pifb_pkg::APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic dma_b_abort_evt,
  input wire logic twi_a_tx_evt,
  input wire logic twi_a_rx_evt,
  input wire logic buffer_clear_bit,
  input wire logic [PWM_GRP_W-1:0] pwm_b_group_flag_reg,
  input wire logic [PWM_GRP_W-1:0] pwm_c_group_flag_reg,
  input wire logic [SPI_FLAG_W-1:0] spi_b_flag_reg,
  input wire logic spi_b_tx_req,
  input wire logic [TWI_ERR_W-1:0] twi_a_error_reg,
  input wire logic [TWI_PROTO_W-1:0] twi_a_protocol_flag_reg,
  input wire logic [UART_FLAG_W-1:0] uart_b_flag_reg,
  input wire logic [UART_ERR_W-1:0] uart_b_error_reg,
  input wire logic uart_b_rx_req,
  input wire logic [pifb_pkg::FLAG_W-1:0] periph_irq_req_five,
  input wire logic [pifb_pkg::FLAG_W-1:0] periph_irq_req_six,
  input wire logic [pifb_pkg::FLAG_W-1:0] periph_irq_req_seven,
  input wire logic [pifb_pkg::FLAG_W-1:0] periph_irq_req_eight
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic wr_six_zero;
  assign wr_six_zero = psel && penable && pready && pwrite && paddr == ADDR_REQ_SIX && pstrb[0] && !pwdata[7];
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && ce;
  endsequence
  // zero wait states after a setup
  property p_answer;
    s_setup ##1 s_access |-> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no pready in access");
  property p_set;
    ce && dma_b_abort_evt |=> periph_irq_req_six[7];
  endproperty
  a_set: assert property (p_set) else $error("event did not set flag");
  property p_sticky;
    ce && periph_irq_req_six[7] && !wr_six_zero |=> periph_irq_req_six[7];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");
  property p_pwm;
    ce |=> periph_irq_req_five[7] == ($past(pwm_b_group_flag_reg) != '0)
      && periph_irq_req_seven[7] == ($past(pwm_c_group_flag_reg) != '0);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm mirror wrong");
  property p_spi;
    ce |=> periph_irq_req_five[2] == ($past(spi_b_flag_reg) != '0);
  endproperty
  a_spi: assert property (p_spi) else $error("spi mirror wrong");
  property p_ro;
    ce |=> periph_irq_req_five[1] == $past(spi_b_tx_req) && periph_irq_req_eight[0] == $past(uart_b_rx_req);
  endproperty
  a_ro: assert property (p_ro) else $error("tx rx mirror wrong");
  property p_twi;
    ce |=> periph_irq_req_seven[3:2] == {($past(twi_a_error_reg) != '0), ($past(twi_a_protocol_flag_reg) != '0)};
  endproperty
  a_twi: assert property (p_twi) else $error("twi mirror wrong");
  property p_uart;
    ce |=> periph_irq_req_eight[3:2] == {($past(uart_b_flag_reg) != '0), ($past(uart_b_error_reg) != '0)};
  endproperty
  a_uart: assert property (p_uart) else $error("uart mirror wrong");
  property p_bufclr;
    ce && buffer_clear_bit && !twi_a_tx_evt && !twi_a_rx_evt |=> periph_irq_req_seven[1:0] == 2'b00;
  endproperty
  a_bufclr: assert property (p_bufclr) else $error("buffer clear ignored");
  property p_unused;
    periph_irq_req_five[6:3] == 4'h0 && periph_irq_req_six[1] == 1'b0 && periph_irq_req_seven[4] == 1'b0
      && periph_irq_req_eight[6] == 1'b0 && periph_irq_req_eight[4] == 1'b0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
endmodule : pifb_flag_bank_sva

bind pifb_flag_bank pifb_flag_bank_sva #(.PWM_GRP_W(PWM_GRP_W), .SPI_FLAG_W(SPI_FLAG_W), .TWI_ERR_W(TWI_ERR_W),
  .TWI_PROTO_W(TWI_PROTO_W), .UART_FLAG_W(UART_FLAG_W), .UART_ERR_W(UART_ERR_W)) pifb_flag_bank_sva_inst (
  .core_clk(core_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .dma_b_abort_evt(dma_b_abort_evt),
  .twi_a_tx_evt(twi_a_tx_evt), .twi_a_rx_evt(twi_a_rx_evt), .buffer_clear_bit(buffer_clear_bit),
  .pwm_b_group_flag_reg(pwm_b_group_flag_reg), .pwm_c_group_flag_reg(pwm_c_group_flag_reg),
  .spi_b_flag_reg(spi_b_flag_reg), .spi_b_tx_req(spi_b_tx_req), .twi_a_error_reg(twi_a_error_reg),
  .twi_a_protocol_flag_reg(twi_a_protocol_flag_reg), .uart_b_flag_reg(uart_b_flag_reg),
  .uart_b_error_reg(uart_b_error_reg), .uart_b_rx_req(uart_b_rx_req), .periph_irq_req_five(periph_irq_req_five),
  .periph_irq_req_six(periph_irq_req_six), .periph_irq_req_seven(periph_irq_req_seven),
  .periph_irq_req_eight(periph_irq_req_eight));

`default_nettype wire

// ### pifb_mirror.sv
`timescale 1ns/1ps
`default_nettype none

module pifb_mirror #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] src,
  output logic flag_q
);

  // no software path: the flag follows the source register only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      flag_q <= |src;
    end
  end

endmodule : pifb_mirror

`default_nettype wire

// ### pifb_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module pifb_periph_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [13:0] fire,
  output logic [13:0] evt_q
);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      evt_q <= 14'h0;
    end else begin
      // one-cycle pulses
      // a held request only re-fires every other cycle
      evt_q <= fire & ~evt_q;
    end
  end
endmodule : pifb_periph_model

`default_nettype wire

// ### pifb_pkg.sv
package pifb_pkg;

  localparam int APB_AW = 16;
  localparam int APB_DW = 32;
  localparam int FLAG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_REQ_FIVE = 12'h4b8;
  localparam logic [11:0] IDX_REQ_SIX = 12'h4b9;
  localparam logic [11:0] IDX_REQ_SEVEN = 12'h4ba;
  localparam logic [11:0] IDX_REQ_EIGHT = 12'h4bb;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h4c0;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h4c1;

  localparam logic [APB_AW-1:0] ADDR_REQ_FIVE = {2'b00, IDX_REQ_FIVE, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_REQ_SIX = {2'b00, IDX_REQ_SIX, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_REQ_SEVEN = {2'b00, IDX_REQ_SEVEN, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_REQ_EIGHT = {2'b00, IDX_REQ_EIGHT, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_IRQ_STATUS = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_IRQ_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};

  // periph_irq_req_five (upper neighbour bits only)
  localparam int B5_PWM_B_PARAM = 7;
  localparam int B5_SPI_B_SUMMARY = 2;
  localparam int B5_SPI_B_TX = 1;
  localparam int B5_SPI_B_RX = 0;
  // periph_irq_req_six
  localparam int B6_DMA_B_ABORT = 7;
  localparam int B6_DMA_B_OVERRUN = 6;
  localparam int B6_DMA_B_DEST = 5;
  localparam int B6_DMA_B_SRC = 4;
  localparam int B6_NUM_OSC = 3;
  localparam int B6_WAVE_GEN = 2;
  localparam int B6_EXT_IRQ_ONE = 0;
  // periph_irq_req_seven
  localparam int B7_PWM_C_PARAM = 7;
  localparam int B7_PWM_C_PERIOD = 6;
  localparam int B7_LOGIC_CELL_C = 5;
  localparam int B7_TWI_A_ERROR = 3;
  localparam int B7_TWI_A_SUMMARY = 2;
  localparam int B7_TWI_A_TX = 1;
  localparam int B7_TWI_A_RX = 0;
  // periph_irq_req_eight
  localparam int B8_MEM_SCANNER = 7;
  localparam int B8_LOGIC_CELL_D = 5;
  localparam int B8_UART_B_SUMMARY = 3;
  localparam int B8_UART_B_FRAMING = 2;
  localparam int B8_UART_B_TX = 1;
  localparam int B8_UART_B_RX = 0;

  localparam logic [FLAG_W-1:0] REQ_RESET = 8'h00;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

endpackage : pifb_pkg

// ### pifb_sticky_bank.sv
`timescale 1ns/1ps
`default_nettype none

module pifb_sticky_bank #(
  parameter int W = 11
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] set_evt,
  input wire logic [W-1:0] wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] flag_q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          flag_q[i] <= 1'b0;
        end else if (ce) begin
          // an event in the same cycle as a software write wins
          if (set_evt[i]) begin
            flag_q[i] <= 1'b1;
          end else if (wr_en[i]) begin
            flag_q[i] <= wr_data[i];
          end
        end
      end
    end
  endgenerate

endmodule : pifb_sticky_bank

`default_nettype wire

// ### test_peripheral_irq_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none

module test_peripheral_irq_flag_bank;
  import pifb_pkg::*;
  logic core_clk = 0, rstn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] req_lvl = '0;
  logic [13:0] fire = '0, evt;
  logic [6:0][7:0] lv = '0;
  logic [FLAG_W-1:0] r5, r6, r7, r8;
  logic [31:0] rng = 32'h11, rr;
  logic [32:0] exp_q [$];
  logic [APB_AW-1:0] al [6] = '{ADDR_REQ_FIVE, ADDR_REQ_SIX, ADDR_REQ_SEVEN, ADDR_REQ_EIGHT, ADDR_IRQ_STATUS,
    ADDR_IRQ_MASK};
  int num_errors = 0, num_checks = 0, cyc = 0;

  always #5 core_clk = ~core_clk;

  pifb_periph_model pifb_periph_model_inst (.core_clk(core_clk), .rstn(rstn), .fire(fire), .evt_q(evt));

  pifb_flag_bank pifb_flag_bank_inst (.core_clk(core_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_b_abort_evt(evt[0]), .dma_b_overrun_evt(evt[1]), .dma_b_dest_count_evt(evt[2]),
    .dma_b_src_count_evt(evt[3]), .num_osc_evt(evt[4]), .wave_gen_evt(evt[5]), .ext_irq_one_evt(evt[6]),
    .pwm_c_period_evt(evt[7]), .logic_cell_c_evt(evt[8]), .mem_scanner_evt(evt[9]), .logic_cell_d_evt(evt[10]),
    .twi_a_tx_evt(evt[11]), .twi_a_rx_evt(evt[12]), .buffer_clear_bit(evt[13]), .pwm_b_group_flag_reg(lv[0]),
    .pwm_c_group_flag_reg(lv[1]), .spi_b_flag_reg(lv[2]), .spi_b_tx_req(req_lvl[3]), .spi_b_rx_req(req_lvl[2]),
    .twi_a_error_reg(lv[3]), .twi_a_protocol_flag_reg(lv[4]), .uart_b_flag_reg(lv[5]), .uart_b_error_reg(lv[6]),
    .uart_b_tx_req(req_lvl[1]), .uart_b_rx_req(req_lvl[0]), .periph_irq_req_five(), .periph_irq_req_six(),
    .periph_irq_req_seven(), .periph_irq_req_eight(), .irq(irq));

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xorshift

  task automatic fail(input string msg);
    num_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic check_rd(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask : check_rd

  task automatic check_irq(input logic exp);
    @(negedge core_clk);
    num_checks++;
    if (irq !== exp) fail($sformatf("irq %b expected %b", irq, exp));
  endtask : check_irq

  // master holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d, input logic [32:0] exp);
    @(posedge core_clk);
    if (!wr) exp_q.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // pready ends this wait; only the bench timeout ends it if pready never comes
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [APB_AW-1:0] a, input logic [7:0] d);
    apb(1'b0, a, 8'h00, {25'h0, d});
  endtask : rd

  task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic pulse(input logic [13:0] v);
    @(posedge core_clk);
    fire <= v;
    @(posedge core_clk);
    fire <= 14'h0;
    repeat (3) @(posedge core_clk);
  endtask : pulse

  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) fail("read without note");
      else check_rd({pslverr, prdata}, exp_q.pop_front());
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail("timeout");
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (al[i]) rd(al[i], 8'h00);
    $display("test reset done");
    for (int b = 0; b < 7; b++) pulse(14'h1 << b);
    rd(ADDR_REQ_SIX, 8'hfd);
    wr(ADDR_REQ_SIX, 8'h00);
    rd(ADDR_REQ_SIX, 8'h00);
    wr(ADDR_REQ_SIX, 8'hff);
    rd(ADDR_REQ_SIX, 8'hfd);
    wr(ADDR_REQ_SIX, 8'h00);
    for (int b = 7; b < 13; b++) pulse(14'h1 << b);
    rd(ADDR_REQ_SEVEN, 8'h63);
    rd(ADDR_REQ_EIGHT, 8'ha0);
    wr(ADDR_REQ_SEVEN, 8'h00);
    wr(ADDR_REQ_EIGHT, 8'hff);
    rd(ADDR_REQ_SEVEN, 8'h03);
    rd(ADDR_REQ_EIGHT, 8'ha0);
    // event wins over a clear in the same cycle
    pulse(14'h2800);
    rd(ADDR_REQ_SEVEN, 8'h02);
    pulse(14'h2000);
    rd(ADDR_REQ_SEVEN, 8'h00);
    wr(ADDR_REQ_EIGHT, 8'h00);
    $display("test sticky done");
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      for (int k = 0; k < 7; k++) begin
        rr = xorshift();
        lv[k] <= (rr[8] && i < 5) ? rr[7:0] : 8'h00;
      end
      rr = xorshift();
      req_lvl <= (i < 5) ? rr[3:0] : 4'h0;
      wr(ADDR_REQ_FIVE, rr[11:4]);
      r5 = {|lv[0], 4'h0, |lv[2], req_lvl[3], req_lvl[2]};
      r7 = {|lv[1], 3'h0, |lv[3], |lv[4], 2'b00};
      r8 = {4'h0, |lv[5], |lv[6], req_lvl[1], req_lvl[0]};
      rd(ADDR_REQ_FIVE, r5);
      rd(ADDR_REQ_SEVEN, r7);
      rd(ADDR_REQ_EIGHT, r8);
    end
    $display("test mirror done");
    wr(ADDR_IRQ_STATUS, 8'h0f);
    wr(ADDR_IRQ_MASK, 8'h02);
    check_irq(1'b0);
    pulse(14'h0040);
    check_irq(1'b1);
    rd(ADDR_IRQ_STATUS, 8'h02);
    wr(ADDR_IRQ_MASK, 8'h00);
    check_irq(1'b0);
    wr(ADDR_IRQ_MASK, 8'h02);
    check_irq(1'b1);
    wr(ADDR_IRQ_STATUS, 8'h02);
    check_irq(1'b0);
    rd(ADDR_REQ_SIX, 8'h01);
    wr(ADDR_REQ_SIX, 8'h00);
    $display("test irq done");
    // setup seen with ce low must still be answered once ce returns
    @(posedge core_clk);
    ce <= 1'b0;
    fork
      rd(ADDR_REQ_SIX, 8'h00);
      begin
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
      end
    join
    $display("test enable done");
    apb(1'b0, 16'h1400, 8'h00, {1'b1, 32'h0});
    $display("test unmapped done");
    repeat (3) @(posedge core_clk);
    conclude();
  end
endmodule : test_peripheral_irq_flag_bank

`default_nettype wire
